// ---- hw/cso_pkg.sv ----
// cso_pkg: constants for the select option control block
// ----------------------------------------------------------
// Overview of operation
// [RULE1] mode bit: 0 async, 1 slow-clock sync
// [RULE2] async select with address or data strobe
// [RULE3] direction field: read, write, or both
// [RULE4] async cycles end on acknowledge or autovector
// [RULE5] ack field: waits, fast end, external
// [RULE6] one clock per wait; zero wait three cycles
// [RULE7] fast termination gives a two-cycle access
// [RULE8] first acknowledge ends the cycle at once
// [RULE9] external option waits forever for acknowledge
// [RULE10] sync match pends until bus interface agrees
// [RULE11] sync byte transfers run back to back
// [RULE12] sync cycles ignore acknowledge and ack field
// [RULE13] software keeps autovector off on sync selects
// [RULE14] software sets bus monitor above two slow clocks
// [RULE15] byte field gates select by port size
// [RULE16] reset: ordinary byte off, boot both bytes
// [RULE17] disabled byte field blocks select and responses
// [RULE18] autovector bit enables internal autovector
// [RULE19] space field restricts access type
// [RULE20] software avoids counter clash on shared matches
// [RULE21] software keeps processor-space selects off data
// [RULE22] interrupt level compared during acknowledge cycles
// [RULE23] select needs space, address, direction, byte match
// [RULE24] reserved direction code matches nothing
// ----------------------------------------------------------
package cso_pkg;
  localparam int NCH  = 12;
  localparam int BOOT = 11;
  // option word layout
  localparam int MODE_B = 15;
  localparam int BYTE_L = 13;
  localparam int RW_L   = 11;
  localparam int STROBE_SELECT_B = 10;
  localparam int ACK_L  = 6;
  localparam int SPC_L  = 4;
  localparam int IPL_L  = 1;
  localparam int AUTOVECTOR_RESPONSE_B = 0;
  localparam logic [3:0] ACK_FAST = 4'hE;
  localparam logic [3:0] ACK_EXT  = 4'hF;
  localparam logic [1:0] RW_RD    = 2'h1;
  localparam logic [1:0] RW_WR    = 2'h2;
  localparam logic [1:0] RW_BOTH  = 2'h3;
  localparam logic [1:0] BY_LOW   = 2'h1;
  localparam logic [1:0] BY_UP    = 2'h2;
  localparam logic [1:0] BY_BOTH  = 2'h3;
  localparam logic [1:0] SP_CPU   = 2'h0;
  localparam logic [1:0] SP_USER  = 2'h1;
  localparam logic [1:0] SP_SUPV  = 2'h2;
  localparam logic [2:0] FC_CPU   = 3'h7;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  // reset words
  localparam logic [15:0] OPT_RST  = 16'h1B70;
  localparam logic [15:0] BOOT_RST = 16'h7B70;
  localparam logic [11:0] P16_RST  = 12'h800;
  // register byte addresses
  localparam logic [11:0] OPT_BASE = 12'h000;
  localparam logic [11:0] P16_OFF  = 12'h030;
  localparam logic [11:0] STAT_OFF = 12'h034;
  // clock and wait timing
  localparam int CLK_NS = 50;
  localparam int FAST_CYC = 2;
  localparam int ZERO_CYC = 3;
  localparam logic [3:0] FAST_LOAD = 4'(FAST_CYC - 2);
  localparam logic [3:0] WAIT_ADD  = 4'(ZERO_CYC - 3);
endpackage

// ---- hw/cso_if.sv ----
// cso_if: match and wait-counter signals between submodules
`timescale 1ns/1ps
`default_nettype none
interface cso_if;
  import cso_pkg::*;
  logic [NCH-1:0][15:0] opt;
  logic [NCH-1:0]       port16;
  logic [NCH-1:0]       addr_hit;
  logic                 rd;
  logic [2:0]           fc;
  logic                 a0;
  logic [1:0]           siz;
  logic [2:0]           lvl;
  logic [NCH-1:0]       hit;
  logic                 ack_int;
  logic [3:0]           ack_code;
  logic                 autovector_response_req;
  logic                 start;
  logic                 stop;
  logic                 done;
  modport matcher (input opt, port16, addr_hit, rd, fc, a0,
                   siz, lvl, output hit, ack_int, ack_code,
                   autovector_response_req);
  modport waiter  (input start, stop, ack_code, output done);
  modport ctrl    (output opt, port16, addr_hit, rd, fc, a0,
                   siz, lvl, start, stop, input hit, ack_int,
                   ack_code, autovector_response_req, done);
endinterface // cso_if
`default_nettype wire

// ---- hw/cso_match.sv ----
// cso_match: per-channel qualification of the current access
`timescale 1ns/1ps
`default_nettype none
module cso_match
  import cso_pkg::*;
(
  cso_if.matcher m
);
  logic lower;
  logic upper;
  logic cpu;
  logic [NCH-1:0] int_en;
  assign lower = m.a0 | (m.siz != SIZ_BYTE);
  assign upper = ~m.a0;
  assign cpu   = (m.fc == FC_CPU);

  // one qualifier per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [1:0] by;
    logic [1:0] rw;
    logic [1:0] sp;
    logic [2:0] interrupt_level_field;
    logic       ok_by;
    logic       ok_rw;
    logic       ok_sp;
    logic       ok_ip;
    assign by  = m.opt[i][BYTE_L+1:BYTE_L];
    assign rw  = m.opt[i][RW_L+1:RW_L];
    assign sp  = m.opt[i][SPC_L+1:SPC_L];
    assign interrupt_level_field = m.opt[i][IPL_L+2:IPL_L];
    // zero byte field never enables
    assign ok_by = (by != 2'h0) & (~m.port16[i] | (by == BY_BOTH)
                 | ((by == BY_LOW) & lower)
                 | ((by == BY_UP) & upper)); // RULE15 RULE17
    // reserved code falls through to no match
    assign ok_rw = (rw == RW_BOTH) | ((rw == RW_RD) & m.rd)
                 | ((rw == RW_WR) & ~m.rd); // RULE3 RULE24
    assign ok_sp = (sp == SP_CPU)  ? cpu
                 : (sp == SP_USER) ? ~m.fc[2]
                 : (sp == SP_SUPV) ? (m.fc[2] & ~cpu)
                 : ~cpu; // RULE19
    assign ok_ip = ~cpu | (interrupt_level_field == 3'h0) | (interrupt_level_field == m.lvl); // RULE22
    assign m.hit[i] = m.addr_hit[i] & ok_by & ok_rw & ok_sp
                    & ok_ip; // RULE23
    assign int_en[i] = m.hit[i] & ~m.opt[i][MODE_B]
                     & (m.opt[i][ACK_L+3:ACK_L] != ACK_EXT);
  end

  // shortest wait wins; fast wraps to zero so it sorts first
  always_comb begin
    m.ack_code = ACK_EXT;
    m.autovector_response_req = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (int_en[i] && (m.ack_code == ACK_EXT ||
          m.opt[i][ACK_L+3:ACK_L] + 4'h2 < m.ack_code + 4'h2))
        m.ack_code = m.opt[i][ACK_L+3:ACK_L]; // RULE5
      if (m.hit[i] && !m.opt[i][MODE_B] && m.opt[i][AUTOVECTOR_RESPONSE_B])
        m.autovector_response_req = 1'b1; // RULE18
    end
  end
  assign m.ack_int = |int_en | m.autovector_response_req;
endmodule // cso_match
`default_nettype wire

// ---- hw/cso_wait.sv ----
// cso_wait: shared wait-state counter for internal acknowledge
`timescale 1ns/1ps
`default_nettype none
module cso_wait
  import cso_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  cso_if.waiter     w
);
  logic [3:0] cnt_q;
  logic       run_q;

  // n waits load n, so done lands n+1 cycles after the start cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      run_q <= 1'b0;
    end else if (w.start) begin
      cnt_q <= (w.ack_code == ACK_FAST) ? FAST_LOAD
             : (w.ack_code == ACK_EXT) ? WAIT_ADD
             : w.ack_code + WAIT_ADD; // RULE6 RULE7
      run_q <= 1'b1;
    end else if (w.stop || w.done) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign w.done = run_q & (cnt_q == 4'h0);
endmodule // cso_wait
`default_nettype wire

// ---- hw/cso_top.sv ----
// cso_top: select option control with its apb register file
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cso_top
  import cso_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] addr_match,
  input  wire logic        cycle_start,
  input  wire logic        bus_read,
  input  wire logic [2:0]  bus_fc,
  input  wire logic        bus_addr0,
  input  wire logic [1:0]  bus_size,
  input  wire logic [2:0]  iack_level,
  input  wire logic        address_strobe,
  input  wire logic        data_strobe,
  input  wire logic        data_size_ack_n,
  input  wire logic        autovector_response_n,
  input  wire logic        ebi_timing_ok,
  input  wire logic        sync_cycle_done,
  input  wire logic        sync_next_byte,
  output logic      [11:0] select_n,
  output logic             int_data_size_ack,
  output logic             int_autovector,
  output logic             cycle_end,
  output logic             sync_pending
);

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ASYNC,
    ST_PEND,
    ST_SYNC
  } cso_state_t;

  cso_if ci ();

  cso_state_t           st_q;
  cso_state_t           st_d;
  logic [NCH-1:0][15:0] opt_q;
  logic [NCH-1:0]       p16_q;
  logic [NCH-1:0]       hit_q;
  logic                 autovector_response_q;
  logic                 ack_int_q;
  logic [2:0]           ack_s_q;
  logic [2:0]           av_s_q;
  logic                 ext_ack_q;
  logic                 ext_av_q;
  logic [11:0]          sel_n_q;
  logic [11:0]          sel_n_d;
  logic                 idsack_q;
  logic                 iavec_q;
  logic                 end_q;
  logic                 pend_q;
  logic [31:0]          rdata_q;
  logic                 rdy_q;
  logic                 err_q;

  // ----------------------------------------------------------
  // submodules
  // ----------------------------------------------------------
  assign ci.opt      = opt_q;
  assign ci.port16   = p16_q;
  assign ci.addr_hit = addr_match;
  assign ci.rd       = bus_read;
  assign ci.fc       = bus_fc;
  assign ci.a0       = bus_addr0;
  assign ci.siz      = bus_size;
  assign ci.lvl      = iack_level;

  cso_match u_match (
    .m (ci.matcher)
  );

  cso_wait u_wait (
    .pclk    (pclk),
    .presetn (presetn),
    .w       (ci.waiter)
  );

  // ----------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------
  logic [3:0] widx;
  logic       opt_sel;
  logic       p16_sel;
  logic       stat_sel;
  logic       mapped;
  logic       setup;
  logic       wr_go;
  logic [31:0] rd_mux;

  assign widx     = paddr[5:2];
  assign opt_sel  = (paddr[11:6] == OPT_BASE[11:6])
                  & (paddr[1:0] == 2'h0)
                  & (widx < 4'(NCH));
  assign p16_sel  = (paddr == P16_OFF);
  assign stat_sel = (paddr == STAT_OFF);
  assign mapped   = opt_sel | p16_sel | stat_sel;
  assign setup    = psel & ~penable & ~rdy_q;
  assign wr_go    = psel & penable & rdy_q & pwrite & mapped;

  // narrow registers read back in the low bits
  assign rd_mux = opt_sel  ? {16'h0, opt_q[widx]}
                : p16_sel  ? {20'h0, p16_q}
                : stat_sel ? {17'h0, st_q, pend_q,
                              ~sel_n_q[NCH-1:0]}
                : 32'h0;

  // ready follows setup by one clock: one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      rdy_q   <= setup;
      err_q   <= setup & ~mapped;
      rdata_q <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------
  // option and port-size registers
  // ----------------------------------------------------------
  // boot channel starts enabled for both bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        opt_q[i] <= (i == BOOT) ? BOOT_RST : OPT_RST; // RULE16
      end
      p16_q <= P16_RST;
    end else if (wr_go && opt_sel) begin
      opt_q[widx] <= pwdata[15:0];
    end else if (wr_go && p16_sel) begin
      p16_q <= pwdata[NCH-1:0];
    end
  end

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  // first stage is looked at by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s_q   <= 3'h7;
      av_s_q    <= 3'h7;
      ext_ack_q <= 1'b0;
      ext_av_q  <= 1'b0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], data_size_ack_n};
      av_s_q  <= {av_s_q[1:0], autovector_response_n};
      if (ack_s_q[1] == ack_s_q[2])
        ext_ack_q <= ~ack_s_q[2];
      if (av_s_q[1] == av_s_q[2])
        ext_av_q <= ~av_s_q[2];
    end
  end

  // ----------------------------------------------------------
  // cycle control
  // ----------------------------------------------------------
  logic go;
  logic any_async;
  logic any_sync;
  logic ext_end;
  logic int_end;
  logic fast_now;
  logic autovector_response_now;
  logic [NCH-1:0] cur_hit;
  logic [NCH-1:0] mode_v;
  logic [NCH-1:0] strobe_select_v;

  for (genvar i = 0; i < NCH; i++) begin : g_fld
    assign mode_v[i] = opt_q[i][MODE_B];
    assign strobe_select_v[i] = opt_q[i][STROBE_SELECT_B];
  end

  assign go        = cycle_start & (st_q == ST_IDLE);
  assign any_async = |(ci.hit & ~mode_v); // RULE1
  assign any_sync  = |(ci.hit & mode_v);
  // external acknowledge or autovector ends async cycles
  assign ext_end   = (st_q == ST_ASYNC)
                   & (ext_ack_q | ext_av_q); // RULE4 RULE8
  assign ci.start  = go & any_async & ci.ack_int;
  // fast termination ends in its own start cycle
  assign fast_now  = ci.start & (ci.ack_code == ACK_FAST); // RULE7
  assign int_end   = fast_now | ((st_q == ST_ASYNC) & ci.done & ack_int_q);
  assign ci.stop   = ext_end;
  assign cur_hit   = (st_q == ST_ASYNC) ? hit_q : (go ? ci.hit & ~mode_v : '0);
  assign autovector_response_now  = (st_q == ST_ASYNC) ? autovector_response_q : ci.autovector_response_req;

  // async wins when both kinds match; sync waits for the ebi
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (go && any_async && !fast_now)
          st_d = ST_ASYNC;
        else if (go && !any_async && any_sync)
          st_d = ST_PEND; // RULE10
      end
      ST_ASYNC: begin
        if (ext_end || int_end)
          st_d = ST_IDLE; // RULE8 RULE9
      end
      ST_PEND: begin
        if (ebi_timing_ok)
          st_d = ST_SYNC; // RULE10
      end
      ST_SYNC: begin
        if (sync_cycle_done && !sync_next_byte)
          st_d = ST_IDLE; // RULE11 RULE12
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // latch the matches for the life of the cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ST_IDLE;
      hit_q     <= '0;
      autovector_response_q    <= 1'b0;
      ack_int_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (go) begin
        hit_q     <= any_async ? (ci.hit & ~mode_v)
                               : (ci.hit & mode_v);
        autovector_response_q    <= ci.autovector_response_req;
        ack_int_q <= any_async & ci.ack_int;
      end
    end
  end

  // ----------------------------------------------------------
  // select pins and responses
  // ----------------------------------------------------------
  // async follows the chosen strobe; sync ignores strobe bit
  always_comb begin
    sel_n_d = '1;
    for (int i = 0; i < NCH; i++) begin
      if (cur_hit[i])
        sel_n_d[i] = ~(strobe_select_v[i] ? data_strobe : address_strobe); // RULE2
      if (st_d == ST_SYNC && hit_q[i])
        sel_n_d[i] = 1'b0; // RULE10 RULE11
    end
  end

  // autovector replaces internal acknowledge when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_n_q  <= '1;
      idsack_q <= 1'b0;
      iavec_q  <= 1'b0;
      end_q    <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      sel_n_q  <= sel_n_d;
      idsack_q <= int_end & ~ext_end & ~autovector_response_now; // RULE5
      iavec_q  <= int_end & ~ext_end & autovector_response_now; // RULE18
      end_q    <= ext_end | int_end
                | ((st_q == ST_SYNC) & sync_cycle_done
                   & ~sync_next_byte);
      pend_q   <= (st_d == ST_PEND);
    end
  end

  assign prdata            = rdata_q;
  assign pready            = rdy_q;
  assign pslverr           = err_q;
  assign select_n          = sel_n_q;
  assign int_data_size_ack = idsack_q;
  assign int_autovector    = iavec_q;
  assign cycle_end         = end_q;
  assign sync_pending      = pend_q;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  logic [NCH-1:0] byoff_v;
  logic [NCH-1:0] rwres_v;
  logic           st_fast;
  logic           st_zero;
  for (genvar i = 0; i < NCH; i++) begin : g_chk
    assign byoff_v[i] = (opt_q[i][BYTE_L+1:BYTE_L] == 2'h0);
    assign rwres_v[i] = (opt_q[i][RW_L+1:RW_L] == 2'h0);
  end
  assign st_fast = ci.start & (ci.ack_code == ACK_FAST);
  assign st_zero = ci.start & (ci.ack_code == 4'h0);

  property p_fast_end;
    @(posedge pclk) disable iff (!presetn)
      st_fast |-> ##1 cycle_end;
  endproperty
  a_fast_end: assert property (p_fast_end) // RULE7
    else $error("fast termination not two cycles");

  property p_zero_end;
    @(posedge pclk) disable iff (!presetn)
      st_zero ##1 !(ext_ack_q | ext_av_q) |-> ##1 cycle_end;
  endproperty
  a_zero_end: assert property (p_zero_end) // RULE6
    else $error("zero wait not three cycles");

  property p_ext_end;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_ASYNC && ext_ack_q) |=> cycle_end && st_q == ST_IDLE;
  endproperty
  a_ext_end: assert property (p_ext_end) // RULE8
    else $error("external acknowledge did not end cycle");

  property p_ext_wait;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_ASYNC && !ack_int_q && !ext_ack_q
       && !ext_av_q) |=> !cycle_end;
  endproperty
  a_ext_wait: assert property (p_ext_wait) // RULE9
    else $error("external option ended without acknowledge");

  property p_byte_off;
    @(posedge pclk) disable iff (!presetn)
      $stable(opt_q) |-> !(|(~select_n & byoff_v));
  endproperty
  a_byte_off: assert property (p_byte_off) // RULE17
    else $error("select asserted with byte field disabled");

  property p_rw_rsvd;
    @(posedge pclk) disable iff (!presetn)
      $stable(opt_q) |-> !(|(~select_n & rwres_v));
  endproperty
  a_rw_rsvd: assert property (p_rw_rsvd) // RULE24
    else $error("select asserted with reserved direction");

  property p_sync_noack;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_SYNC) |=> !int_data_size_ack && !int_autovector;
  endproperty
  a_sync_noack: assert property (p_sync_noack) // RULE12
    else $error("acknowledge produced in sync cycle");

  property p_sync_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_PEND && !ebi_timing_ok) |=> sync_pending && (&select_n);
  endproperty
  a_sync_hold: assert property (p_sync_hold) // RULE10
    else $error("sync select before bus timing ok");

  property p_b2b;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_SYNC && sync_cycle_done && sync_next_byte)
        |=> st_q == ST_SYNC && !sync_pending && !cycle_end;
  endproperty
  a_b2b: assert property (p_b2b) // RULE11
    else $error("gap between back to back bytes");

endmodule // cso_top
`default_nettype wire

// ---- verif/cso_periph.sv ----
// cso_periph: external device answering with its acknowledge pin
`timescale 1ns/1ps
`default_nettype none
module cso_periph (
  input  wire logic       pclk,
  input  wire logic       sel_n,
  input  wire logic       en,
  input  wire logic [3:0] dly,
  output logic            ack_n
);
  logic [3:0] cnt_q;
  // ------
  // acknowledge after dly+1 clocks of select; pulled up once released
  // ------
  always @(posedge pclk) begin
    if (sel_n) begin
      cnt_q <= 4'h0;
      ack_n <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (en && cnt_q >= dly) ack_n <= 1'b0;
    end
  end
endmodule // cso_periph
`default_nettype wire

// ---- verif/cso_top_tb.sv ----
// cso_top_tb: scenario bench for the select option control block
`timescale 1ns/1ps
`default_nettype none
module cso_top_tb
  import cso_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        go, rd, a0, as_s, ds_s, ebi_ok, sdone, snext;
  logic        iack, iav, cend, spend, ack_n, av_n, p_en, err;
  logic [11:0] paddr, amatch, sel_n;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0]  fc, lvl;
  logic [1:0]  siz;
  logic [3:0]  p_dly;
  int          bad_count, n_tests, len, cyc, ends, sl, dk, av;

  cso_top i_cso_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_match(amatch), .cycle_start(go), .bus_read(rd), .bus_fc(fc),
    .bus_addr0(a0), .bus_size(siz), .iack_level(lvl),
    .address_strobe(as_s), .data_strobe(ds_s), .data_size_ack_n(ack_n),
    .autovector_response_n(av_n), .ebi_timing_ok(ebi_ok),
    .sync_cycle_done(sdone), .sync_next_byte(snext), .select_n(sel_n),
    .int_data_size_ack(iack), .int_autovector(iav), .cycle_end(cend),
    .sync_pending(spend));
  cso_periph i_cso_periph (.pclk(pclk), .sel_n(sel_n[0]), .en(p_en),
    .dly(p_dly), .ack_n(ack_n));

  // ------
  // clock, watchdog and shared tasks
  // ------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // a hung handshake ends here; ends counts cycle_end pulses
  always @(posedge pclk) begin
    cyc++;
    if (cend === 1'b1) ends <= ends + 1;
    if (cyc == 20000) begin
      bad_count++;
      results;
    end
  end
  task results;
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // ex carries mode, strobe, level and autovector bits
  task automatic opt(input logic [1:0] b, rw, input logic [3:0] ak,
                     input logic [1:0] sp, input logic [15:0] ex);
    apb(1'b1, OPT_BASE, {16'h0, 1'b0, b, rw, 1'b0, ak, sp, 4'h0} | ex);
  endtask
  // cycles to cycle_end (0 = none), plus what was seen meanwhile
  task automatic watch;
    len = 0;
    sl = 0;
    dk = 0;
    av = 0;
    for (int n = 1; n <= 24 && len == 0; n++) begin
      @(posedge pclk);
      if (sel_n[0] === 1'b0) sl = 1;
      if (iack === 1'b1) dk = 1;
      if (iav === 1'b1) av = 1;
      if (cend === 1'b1) len = n;
    end
    repeat (6) @(posedge pclk);
  endtask
  task automatic run(input logic r, input logic [2:0] f);
    @(posedge pclk);
    go <= 1'b1;
    rd <= r;
    fc <= f;
    @(posedge pclk);
    go <= 1'b0;
    watch;
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset;
    apb(1'b0, OPT_BASE, 32'h0);
    chk("opt0 rst", rdat, 32'h1B70);
    apb(1'b0, 12'(4 * BOOT), 32'h0);
    chk("boot rst", rdat, 32'h7B70);
    apb(1'b0, P16_OFF, 32'h0);
    chk("p16 rst", rdat, 32'(P16_RST));
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'b1, 12'h004, 32'hA5A5);
    apb(1'b0, 12'h004, 32'h0);
    chk("opt1", rdat, 32'hA5A5);
    run(1'b1, 3'h5);
    chk("boot len", len, 32'hF);
    chk("off sel", sl, 32'h0);
    amatch <= 12'h001;
    run(1'b1, 3'h5);
    chk("off len", len, 32'h0);
  endtask
  task automatic t_wait;
    for (int n = 0; n < 15; n++) begin
      opt(2'h3, 2'h3, 4'(n), 2'h3, 16'h0);
      run(1'b1, 3'h5);
      chk("len", len, (n == 14) ? 32'h1 : 32'(n + 2));
      chk("ack", dk, 32'h1);
      chk("sel", sl, 32'h1);
    end
  endtask
  // pending forever, then the pin ends it; pin beats the counter
  task automatic t_ext;
    opt(2'h3, 2'h3, ACK_EXT, 2'h3, 16'h0);
    run(1'b1, 3'h5);
    chk("ext wait", len, 32'h0);
    p_en <= 1'b1;
    watch;
    chk("ext end", 32'(len != 0), 32'h1);
    chk("ext int", dk, 32'h0);
    opt(2'h3, 2'h3, 4'hD, 2'h3, 16'h0);
    run(1'b1, 3'h5);
    chk("ext first", 32'(len > 0 && len < 15), 32'h1);
    p_en <= 1'b0;
  endtask
  task automatic t_rw;
    for (int i = 0; i < 8; i++) begin
      opt(2'h3, 2'(i >> 1), ACK_FAST, 2'h3, 16'h0);
      run(i[0], 3'h5);
      chk("rw", len, 32'((i[1] & i[0]) | (i[2] & ~i[0])));
    end
  endtask
  task automatic t_space;
    logic [2:0] f;
    logic       e;
    for (int i = 0; i < 12; i++) begin
      f = (i % 3 == 0) ? 3'h1 : (i % 3 == 1) ? 3'h5 : 3'h7;
      case (i / 3)
        0: e = (f == 3'h7);
        1: e = ~f[2];
        2: e = f[2] && f != 3'h7;
        default: e = f != 3'h7;
      endcase
      opt(2'h3, 2'h3, ACK_FAST, 2'(i / 3), 16'h0);
      run(1'b1, f);
      chk("space", len, 32'(e));
    end
    // acknowledge-only use of a cpu-space select
    for (int j = 0; j < 2; j++) begin
      opt(2'h3, 2'h1, ACK_FAST, 2'h0, j ? 16'h8 : 16'h4);
      run(1'b1, 3'h7);
      chk("level", len, 32'(j));
    end
  endtask
  task automatic t_autovector_response;
    opt(2'h3, 2'h3, 4'h0, 2'h3, 16'h1);
    run(1'b1, 3'h5);
    chk("av len", len, 32'h2);
    chk("av out", av, 32'h1);
    chk("av ack", dk, 32'h0);
    opt(2'h3, 2'h3, ACK_EXT, 2'h3, 16'h0);
    run(1'b1, 3'h5);
    av_n <= 1'b0;
    watch;
    chk("pin av", 32'(len != 0), 32'h1);
    av_n <= 1'b1;
  endtask
  task automatic t_strobe_select;
    for (int j = 0; j < 3; j++) begin
      as_s <= (j == 0);
      ds_s <= (j > 0);
      opt(2'h3, 2'h3, 4'h3, 2'h3, (j < 2) ? 16'h400 : 16'h0);
      run(1'b1, 3'h5);
      chk("strobe", sl, 32'(j == 1));
    end
    {as_s, ds_s} <= 2'h3;
  endtask
  task automatic t_byte;
    apb(1'b1, P16_OFF, 32'h801);
    siz <= SIZ_BYTE;
    for (int i = 0; i < 6; i++) begin
      a0 <= i[0];
      opt(2'(i / 2 + 1), 2'h3, ACK_FAST, 2'h3, 16'h0);
      run(1'b1, 3'h5);
      chk("lane", len, 32'(((i / 2 + 1) & (i[0] ? 1 : 2)) != 0));
    end
    apb(1'b1, P16_OFF, 32'(P16_RST));
    a0 <= 1'b0;
    opt(2'h1, 2'h3, ACK_FAST, 2'h3, 16'h0);
    run(1'b1, 3'h5);
    chk("8 bit", len, 32'h1);
    siz <= 2'h2;
  endtask
  // fast code and acking pin must not end a slow-clock cycle
  task automatic t_sync;
    int e0;
    opt(2'h3, 2'h3, ACK_FAST, 2'h3, 16'h8000);
    p_en <= 1'b1;
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    e0 = ends;
    repeat (4) @(posedge pclk);
    chk("pending", 32'(spend), 32'h1);
    chk("held", 32'(sel_n[0]), 32'h1);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("status", rdat, 32'h5000);
    ebi_ok <= 1'b1;
    repeat (3) @(posedge pclk);
    sdone <= 1'b1;
    snext <= 1'b1;
    @(posedge pclk);
    sdone <= 1'b0;
    snext <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("bytes", 32'(sel_n[0]), 32'h0);
    chk("no end", 32'(ends - e0), 32'h0);
    sdone <= 1'b1;
    @(posedge pclk);
    sdone <= 1'b0;
    watch;
    chk("sync end", len, 32'h1);
    ebi_ok <= 1'b0;
    p_en <= 1'b0;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, rd, a0, ebi_ok, sdone, snext, p_en} = '0;
    {as_s, ds_s, av_n} = 3'h7;
    paddr = 12'h000;
    pwdata = 32'h0;
    amatch = 12'h801;
    fc = 3'h5;
    lvl = 3'h4;
    siz = 2'h2;
    p_dly = 4'h1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_wait;
    t_ext;
    t_rw;
    t_space;
    t_autovector_response;
    t_strobe_select;
    t_byte;
    t_sync;
    results;
  end
endmodule // cso_top_tb
`default_nettype wire
